// ### verilog/sram_host_consts.svh
// Timing constants for the backed SRAM host controller
`ifndef SRAM_HOST_CONSTS_SVH
`define SRAM_HOST_CONSTS_SVH
// Behaviour
// - Host keeps address stable for the whole write cycle.
// - Host keeps ending control high for release hold before next cycle.
// - Host drives data setup before write end and holds it afterwards.
// - Host keeps output drive deasserted throughout write cycles.
// - Host holds write strobe low at least 50 ns.
// - Host has write data valid at least 30 ns before strobe rises.

`define CLK_PERIOD_NS        50
`define STROBE_WIDTH_NS      50
`define DATA_SETUP_NS        30
`define DATA_HOLD_NS         5
`define RELEASE_HOLD_NS      0
`define ADDR_SETUP_NS        0
`define READ_ACCESS_NS       70
`define CEIL_CYC(ns) (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define MAX1(x) (((x) < 1) ? 1 : (x))
`define STROBE_CYC   `MAX1(`CEIL_CYC(`STROBE_WIDTH_NS))
`define SETUP_CYC    `MAX1(`CEIL_CYC(`DATA_SETUP_NS))
`define HOLD_CYC     `MAX1(`CEIL_CYC(`DATA_HOLD_NS))
`define RELEASE_CYC  `MAX1(`CEIL_CYC(`RELEASE_HOLD_NS))
`define READ_CYC     `MAX1(`CEIL_CYC(`READ_ACCESS_NS))
`endif

// ### verilog/sram_host_pkg.sv
// Types shared by the backed SRAM host controller
package sram_host_pkg;
    typedef enum logic [2:0] {
        ST_IDLE    = 3'b000,
        ST_STROBE  = 3'b001,
        ST_HOLD    = 3'b010,
        ST_RELEASE = 3'b011,
        ST_READ    = 3'b100,
        ST_CHECK   = 3'b101
    } phase_type;
    typedef enum logic [1:0] {
        OP_READ  = 2'b00,
        OP_WRITE = 2'b01,
        OP_CHECK = 2'b10
    } op_type;
endpackage

// ### verilog/sram_timer_if.sv
// Interface between the sequencer and its phase timer
`timescale 1ns/1ps
`default_nettype none
interface sram_timer_if;
    logic       load;
    logic [7:0] count;
    logic       done;
    modport owner (output load, output count, input done);
    modport timer (input load, input count, output done);
endinterface
`default_nettype wire

// ### verilog/phase_timer.sv
// Down counter that times each bus phase in clock cycles
`timescale 1ns/1ps
`default_nettype none
module phase_timer (
    input  wire logic    i_clk,
    input  wire logic    i_rst_n,
    sram_timer_if.timer  tmr
);
    typedef struct packed {
        logic [7:0] cnt;
    } state_type;
    state_type state_reg;
    state_type state_next;

    // Load wins over counting so a new phase restarts cleanly
    always_comb begin
        state_next = state_reg;
        if (tmr.load) begin
            state_next.cnt = tmr.count;
        end else if (state_reg.cnt != 8'h00) begin
            state_next.cnt = state_reg.cnt - 8'h01;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    // Done looks at the count only: the sequencer decodes its load from
    // done, so a term in load here would close a combinational loop
    assign tmr.done = (state_reg.cnt == 8'h01);
endmodule
`default_nettype wire

// ### verilog/sram_host.sv
// Host sequencer driving a battery-backed 2K x 8 asynchronous SRAM
`timescale 1ns/1ps
`default_nettype none
`include "sram_host_consts.svh"
module sram_host #(
    parameter int ADDR_W = 11,
    parameter int DATA_W = 8
) (
    input  wire logic                 i_clk,
    input  wire logic                 i_rst_n,
    input  wire logic                 i_req_valid,
    output logic                      o_req_ready,
    input  wire sram_host_pkg::op_type i_req_op,
    input  wire logic [ADDR_W-1:0]    i_req_addr,
    input  wire logic [DATA_W-1:0]    i_req_wdata,
    output logic                      o_rsp_valid,
    output logic [DATA_W-1:0]         o_rsp_rdata,
    output logic                      o_rsp_battery_low,
    output logic [ADDR_W-1:0]         o_address_lines,
    output logic                      o_select_n,
    output logic                      o_strobe_n,
    output logic                      o_drive_n,
    input  wire logic [DATA_W-1:0]    i_data_lines,
    output logic [DATA_W-1:0]         o_data_lines,
    output logic                      o_data_lines_oe
);
    import sram_host_pkg::*;

    // Phase lengths in clock cycles; the strobe phase covers both the
    // minimum strobe width and the data setup, whichever is longer
    localparam int STROBE_MIN_CYC = (`STROBE_CYC > `SETUP_CYC) ?
                                    `STROBE_CYC : `SETUP_CYC;
    localparam logic [7:0] STROBE_LEN  = 8'(STROBE_MIN_CYC);
    localparam logic [7:0] HOLD_LEN    = 8'(`HOLD_CYC);
    localparam logic [7:0] RELEASE_LEN = 8'(`RELEASE_CYC);
    // Two extra cycles pay for the synchroniser on the data pins
    localparam logic [7:0] READ_LEN    = 8'(`READ_CYC + 2);

    typedef struct packed {
        // Sequencing and the request held on the bus
        phase_type         phase;
        op_type            op;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        // Read data, pin controls and answer flags
        logic [DATA_W-1:0] rdata;
        logic              sel_n;
        logic              stb_n;
        logic              drv_n;
        logic              oe;
        logic              rsp;
        logic              low;
        // Two-stage synchroniser on the data pins
        logic [DATA_W-1:0] sync1;
        logic [DATA_W-1:0] sync2;
    } state_type;

    // Idle bus: every control released, host off the data lines
    localparam state_type RESET_STATE = '{
        phase : ST_IDLE,
        op    : OP_READ,
        addr  : '0,
        wdata : '0,
        rdata : '0,
        sel_n : 1'b1,
        stb_n : 1'b1,
        drv_n : 1'b1,
        oe    : 1'b0,
        rsp   : 1'b0,
        low   : 1'b0,
        sync1 : '0,
        sync2 : '0
    };

    state_type state_reg;
    state_type state_next;
    sram_timer_if tmr ();

    phase_timer u_timer (
        .i_clk   (i_clk),
        .i_rst_n (i_rst_n),
        .tmr     (tmr)
    );

    // Data pins cross from the device, two flops before use; only the
    // second flop is read, so a metastable first stage never leaks
    // Sequencer: write = strobe, hold, release; read; check = both
    // A check keeps its op code until the readback has been compared
    always_comb begin
        state_next       = state_reg;
        state_next.sync1 = i_data_lines;
        state_next.sync2 = state_reg.sync1;
        state_next.rsp   = 1'b0;
        tmr.load         = 1'b0;
        tmr.count        = 8'h00;
        // Strobe, hold, release and read are timed by the down counter; a load restarts it
        case (state_reg.phase)
            ST_IDLE: begin
                if (i_req_valid) begin
                    state_next.op    = i_req_op;
                    state_next.addr  = i_req_addr;
                    state_next.wdata = i_req_wdata;
                    state_next.low   = 1'b0;
                    case (i_req_op)
                        OP_READ: begin
                            state_next.sel_n = 1'b0;
                            state_next.drv_n = 1'b0;
                            state_next.phase = ST_READ;
                            tmr.load         = 1'b1;
                            tmr.count        = READ_LEN;
                        end
                        OP_WRITE, OP_CHECK: begin
                            // Output drive stays high, no contention
                            state_next.drv_n = 1'b1;
                            state_next.sel_n = 1'b0;
                            state_next.stb_n = 1'b0;
                            state_next.oe    = 1'b1;
                            state_next.phase = ST_STROBE;
                            tmr.load         = 1'b1;
                            tmr.count        = STROBE_LEN;
                        end
                        default: begin
                            // Unused code: answered at once, address latched but controls untouched
                            state_next.rsp = 1'b1;
                        end
                    endcase
                end
            end

            ST_STROBE: begin
                if (tmr.done) begin
                    // Strobe rises first and alone ends the write
                    state_next.stb_n = 1'b1;
                    state_next.phase = ST_HOLD;
                    tmr.load         = 1'b1;
                    tmr.count        = HOLD_LEN;
                end
            end

            ST_HOLD: begin
                if (tmr.done) begin
                    // Data and address held past the strobe edge
                    state_next.oe    = 1'b0;
                    state_next.sel_n = 1'b1;
                    state_next.phase = ST_RELEASE;
                    tmr.load         = 1'b1;
                    tmr.count        = RELEASE_LEN;
                end
            end

            ST_READ: begin
                if (tmr.done) begin
                    state_next.rdata = state_reg.sync2;
                    state_next.sel_n = 1'b1;
                    state_next.drv_n = 1'b1;
                    if (state_reg.op == OP_CHECK) begin
                        // Mismatch means the first write was blocked
                        state_next.low = (state_reg.sync2 != state_reg.wdata);
                        // Readback compared, so the release now answers
                        state_next.op  = OP_READ;
                    end else begin
                        state_next.low = 1'b0;
                    end
                    state_next.phase = ST_RELEASE;
                    tmr.load         = 1'b1;
                    tmr.count        = RELEASE_LEN;
                end
            end

            ST_RELEASE: begin
                // Controls stay high for the release hold
                if (tmr.done) begin
                    if (state_reg.op == OP_CHECK) begin
                        // Write half of a check: go on to the readback
                        state_next.phase = ST_CHECK;
                    end else begin
                        state_next.rsp   = 1'b1;
                        state_next.phase = ST_IDLE;
                    end
                end
            end

            ST_CHECK: begin
                // Second half of a check: read back after the write
                if (state_reg.rsp == 1'b0 && state_reg.sel_n) begin
                    state_next.sel_n = 1'b0;
                    state_next.drv_n = 1'b0;
                    state_next.phase = ST_READ;
                    state_next.low   = 1'b0;
                    tmr.load         = 1'b1;
                    tmr.count        = READ_LEN;
                end
            end

            // Unused phase codes fall back to idle
            default: begin
                state_next.phase = ST_IDLE;
            end
        endcase
    end

    // Asynchronous reset lands on the idle bus
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_reg <= RESET_STATE;
        end else begin
            state_reg <= state_next;
        end
    end

    // Requester handshake; ready is decoded from the phase register
    assign o_req_ready       = (state_reg.phase == ST_IDLE);
    assign o_rsp_valid       = state_reg.rsp;
    assign o_rsp_rdata       = state_reg.rdata;
    assign o_rsp_battery_low = state_reg.low;

    // Bus pins come straight from flops, so no glitch reaches the device
    assign o_address_lines   = state_reg.addr;
    assign o_select_n        = state_reg.sel_n;
    assign o_strobe_n        = state_reg.stb_n;
    assign o_drive_n         = state_reg.drv_n;
    assign o_data_lines      = state_reg.wdata;
    assign o_data_lines_oe   = state_reg.oe;
endmodule
`default_nettype wire

// ### verification/sram_host_properties.sv
// Pin-level checks on the host side of the SRAM bus
`timescale 1ns/1ps
`default_nettype none
module sram_host_properties #(
    parameter int ADDR_W = 11,
    parameter int DATA_W = 8
) (
    input  wire logic              i_clk,
    input  wire logic              i_rst_n,
    input  wire logic              o_rsp_valid,
    input  wire logic              o_rsp_battery_low,
    input  wire logic [ADDR_W-1:0] o_address_lines,
    input  wire logic              o_select_n,
    input  wire logic              o_strobe_n,
    input  wire logic              o_drive_n,
    input  wire logic [DATA_W-1:0] o_data_lines,
    input  wire logic              o_data_lines_oe
);
    // One domain, so clock and reset are shared by every check
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    chk_addr_stable: assert property (
        !o_select_n && !$past(o_select_n) |-> $stable(o_address_lines))
        else $error("address moved while selected");
    chk_release_hold: assert property (
        $rose(o_select_n) |-> o_select_n [*2])
        else $error("select returned low too soon");
    chk_data_hold: assert property (
        $rose(o_strobe_n) |-> o_data_lines_oe && $stable(o_data_lines))
        else $error("write data not held after strobe");
    chk_data_setup: assert property (
        !o_strobe_n |-> o_data_lines_oe ##1 $stable(o_data_lines))
        else $error("write data not valid under strobe");
    chk_strobe_width: assert property (
        $fell(o_strobe_n) |-> !o_select_n ##1 o_strobe_n)
        else $error("strobe pulse not one cycle");
    chk_no_drive_write: assert property (
        !o_strobe_n |-> o_drive_n)
        else $error("output drive low during write");
    chk_oe_no_drive: assert property (
        o_data_lines_oe |-> o_drive_n)
        else $error("host drives data while device may");
    chk_write_frame: assert property (
        $fell(o_strobe_n) |-> ##1 (!o_select_n && o_strobe_n)
            ##1 (o_select_n && !o_data_lines_oe) ##1 o_select_n)
        else $error("write frame out of order");
    // Main scenarios: write, read, blocked check
    cov_write: cover property ($fell(o_strobe_n));
    cov_read: cover property ($fell(o_drive_n));
    cov_blocked: cover property (o_rsp_valid && o_rsp_battery_low);
endmodule
bind sram_host sram_host_properties #(.ADDR_W(ADDR_W), .DATA_W(DATA_W))
    u_props (.i_clk(i_clk), .i_rst_n(i_rst_n), .o_rsp_valid(o_rsp_valid),
    .o_rsp_battery_low(o_rsp_battery_low),
    .o_address_lines(o_address_lines), .o_select_n(o_select_n),
    .o_strobe_n(o_strobe_n), .o_drive_n(o_drive_n),
    .o_data_lines(o_data_lines), .o_data_lines_oe(o_data_lines_oe));
`default_nettype wire

// ### verification/sram_backed_model.sv
// Behavioural battery-backed 2K x 8 SRAM facing the host
`timescale 1ns/1ps
`default_nettype none
module sram_backed_model (
    input  wire logic [10:0] i_address_lines,
    input  wire logic        i_select_n,
    input  wire logic        i_strobe_n,
    input  wire logic        i_drive_n,
    input  wire logic [7:0]  i_data_lines,
    input  wire logic        i_vcc_ok,
    input  wire logic        i_battery_bad,
    output logic      [7:0]  o_data_lines
);
    logic [7:0] mem [0:2047];
    logic       battery_low_flag = 1'b0;
    logic [7:0] last_q = 8'h00;
    logic       drive;
    logic       wr;
    // Write window only while supply is good
    assign wr = ~i_select_n & ~i_strobe_n & i_vcc_ok;
    // Battery tested on supply rise
    always @(posedge i_vcc_ok) battery_low_flag = i_battery_bad;
    // Commit at the earlier release; a dropped supply ends it unwritten
    always @(negedge wr) begin
        if (i_vcc_ok && battery_low_flag)
            battery_low_flag = 1'b0;
        else if (i_vcc_ok)
            mem[i_address_lines] = i_data_lines;
    end
    // Strobe or power fail floats the outputs
    assign drive = i_vcc_ok & ~i_select_n & ~i_drive_n & i_strobe_n;
    always @* if (drive) last_q = mem[i_address_lines];
    // Released lines show the inverse, not a stale value
    assign o_data_lines = drive ? last_q : ~last_q;
endmodule
`default_nettype wire

// ### verification/backed_sram_write_and_retention_tb_top.sv
// Self-checking bench for the SRAM host controller
`timescale 1ns/1ps
`default_nettype none
module backed_sram_write_and_retention_tb_top;
    import sram_host_pkg::*;
    logic clk, rst_n, req_valid, req_ready, rsp_valid, rsp_bl;
    op_type req_op;
    logic [10:0] req_addr, addr;
    logic [7:0] req_wdata, rsp_rdata, host_d, mdl_q, bus;
    logic sel_n, stb_n, drv_n, host_oe, vcc_ok, batt_bad;
    int error_cnt = 0;
    int checked = 0;
    // Shared data wire: the host wins only while enabled
    assign bus = host_oe ? host_d : mdl_q;
    always #25 clk = ~clk;
    sram_host u_dut (.i_clk(clk), .i_rst_n(rst_n), .i_req_valid(req_valid),
        .o_req_ready(req_ready), .i_req_op(req_op), .i_req_addr(req_addr),
        .i_req_wdata(req_wdata), .o_rsp_valid(rsp_valid),
        .o_rsp_rdata(rsp_rdata), .o_rsp_battery_low(rsp_bl),
        .o_address_lines(addr), .o_select_n(sel_n), .o_strobe_n(stb_n),
        .o_drive_n(drv_n), .i_data_lines(bus), .o_data_lines(host_d),
        .o_data_lines_oe(host_oe));
    sram_backed_model u_mem (.i_address_lines(addr), .i_select_n(sel_n),
        .i_strobe_n(stb_n), .i_drive_n(drv_n), .i_data_lines(bus),
        .i_vcc_ok(vcc_ok), .i_battery_bad(batt_bad), .o_data_lines(mdl_q));
    task automatic results;
        $display("errors %0d checks %0d", error_cnt, checked);
        if (error_cnt == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic check_eq(input string name, input logic [7:0] seen,
                            input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // One request; ready is high in idle, so it is taken at the next edge
    task automatic run_op(input op_type op, input logic [10:0] a,
                          input logic [7:0] d);
        int n;
        @(posedge clk);
        req_valid <= 1'b1;
        req_op <= op;
        req_addr <= a;
        req_wdata <= d;
        @(posedge clk);
        req_valid <= 1'b0;
        #1 check_eq("busy", {7'h00, req_ready}, 8'h00);
        n = 0;
        do begin
            @(posedge clk);
            #1 n++;
        end while (rsp_valid !== 1'b1 && n < 40);
        if (n >= 40) begin
            error_cnt++;
            results();
        end
        check_eq("ready", {7'h00, req_ready}, 8'h01);
    endtask
    task automatic set_supply(input logic ok, input logic bad);
        @(posedge clk);
        batt_bad <= bad;
        repeat (2) @(posedge clk);
        vcc_ok <= ok;
    endtask
    // Back-to-back writes at both ends of the array, then readback
    task automatic round_trip;
        logic [10:0] at [3] = '{11'h000, 11'h7FF, 11'h2AA};
        logic [7:0] val [3] = '{8'h5A, 8'hC3, 8'h0F};
        for (int i = 0; i < 3; i++) run_op(OP_WRITE, at[i], val[i]);
        for (int i = 0; i < 3; i++) begin
            run_op(OP_READ, at[i], 8'h00);
            check_eq("readback", rsp_rdata, val[i]);
        end
    endtask
    // Weak battery at power-up blocks exactly one write
    task automatic battery_flag;
        run_op(OP_WRITE, 11'h005, 8'h3C);
        set_supply(1'b0, 1'b1);
        set_supply(1'b1, 1'b1);
        run_op(OP_READ, 11'h005, 8'h00);
        check_eq("before check", rsp_rdata, 8'h3C);
        run_op(OP_CHECK, 11'h005, 8'hA5);
        check_eq("flag seen", {7'h00, rsp_bl}, 8'h01);
        check_eq("blocked byte", rsp_rdata, 8'h3C);
        run_op(OP_CHECK, 11'h005, 8'hA5);
        check_eq("flag gone", {7'h00, rsp_bl}, 8'h00);
        check_eq("second write", rsp_rdata, 8'hA5);
    endtask
    // Writes during supply decay are ignored
    task automatic power_fail;
        set_supply(1'b0, 1'b0);
        run_op(OP_WRITE, 11'h005, 8'h11);
        set_supply(1'b1, 1'b0);
        run_op(OP_READ, 11'h005, 8'h00);
        check_eq("protected", rsp_rdata, 8'hA5);
        run_op(OP_READ, 11'h7FF, 8'h00);
        check_eq("neighbour", rsp_rdata, 8'hC3);
    endtask
    initial begin
        {clk, rst_n, req_valid, vcc_ok, batt_bad} = 5'h00;
        req_op = OP_READ;
        req_addr = 11'h000;
        req_wdata = 8'h00;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        vcc_ok <= 1'b1;
        round_trip();
        battery_flag();
        power_fail();
        results();
    end
endmodule
`default_nettype wire
